// [drc_map.svh]
// register map, field positions, reset values and timing counts of the
// playback compressor and its host bridge; definitions only
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

`define ADDR_LATCHED  7'h2c
`define ADDR_FLAGS_B  7'h2d
`define ADDR_LIVE     7'h2e
`define ADDR_IRQ_A    7'h30
`define ADDR_IRQ_B    7'h31
`define ADDR_FLAGS_C  7'h32
`define ADDR_CTRL     7'h44
`define ADDR_HOLD     7'h45
`define ADDR_RATES    7'h46

`define RST_CTRL      8'h00
`define RST_HOLD      8'h00
`define RST_RATES     8'h00
`define RST_IRQ_CFG   8'h00

`define CTRL_EN_L     6
`define CTRL_EN_R     5
`define THR_LSB       2
`define HYS_LSB       0
`define HOLD_LSB      3
`define ATK_LSB       4
`define DEC_LSB       0
`define FLG_BTN       5
`define FLG_HSET      4
`define FLG_THR_L     3
`define FLG_THR_R     2
`define CFG_HSET      7
`define CFG_BTN       6
`define CFG_THR       5
`define CFG_ROUTE     1
`define CFG_TRAIN     0

`define CLK_PERIOD_NS  10
`define IRQ_PULSE_NS   100
`define IRQ_PULSE_CYC  8'((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_PERIOD_NS  2000
`define IRQ_PERIOD_CYC 8'(`IRQ_PERIOD_NS / `CLK_PERIOD_NS)
`define HOLD_UNIT      10'h040

`define GR_ONE_DB     32'h0100_0000
`define GR_MAX        (32'h0000_0030 * `GR_ONE_DB)
`define ATK_MAX_STEP  32'h0400_0000
`define ATK_REF_STEP  32'h0000_0ccd
`define ATK_REF_CODE  4'hb
`define DEC_MAX_STEP  32'h0000_6666
`define DEC_MIN_STEP  32'h0000_0008
`define Q12_ONE       13'h1000

`define HOST_CMD      32'h0000_0000
`define HOST_STATUS   32'h0000_0004
`define CMD_WRITE_BIT 16

`endif

// [drc_pkg.sv]
// types shared by the compressor device end and the host bridge end
package drc_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_ATTACK, ST_HOLD, ST_DECAY} drc_state_type;

  typedef enum logic [1:0] {LK_IDLE, LK_REQ, LK_GAP} link_state_type;

  typedef struct packed {
    drc_state_type   st;
    logic            active;
    logic [31:0]     gr;
    logic [9:0]      hold_cnt;
    logic [32:0]     gain;
    logic [7:0]      ctrl;
    logic [7:0]      hold;
    logic [7:0]      rates;
    logic [1:0][7:0] cfg;
    logic [5:2]      sticky;
    logic [1:0]      live;
    logic            btn_q;
    logic            hset_q;
    logic [7:0]      rdata;
    logic            ready;
    logic [1:0]      train;
    logic [1:0][7:0] pcnt;
    logic [1:0][7:0] per;
    logic            gp_pin;
    logic            do_pin;
  } dev_state_type;

  typedef struct packed {
    link_state_type st;
    logic [6:0]     addr;
    logic [7:0]     wdata;
    logic           wr;
    logic [7:0]     rd_data;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic           gp_q;
    logic           do_q;
  } host_state_type;

endpackage : drc_pkg

// [drc_link_if.sv]
// link between the compressor device and its host bridge: byte-wide
// register port plus the two interrupt-carrying pins; both ends share pclk
`timescale 1ns/100ps

interface drc_link_if;
  logic       reg_sel;
  logic       reg_write;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_ready;
  logic       general_pin_one;
  logic       serial_data_out_pin;

  modport device_end (
    input  reg_sel, reg_write, reg_addr, reg_wdata,
    output reg_rdata, reg_ready, general_pin_one, serial_data_out_pin
  );

  modport host_end (
    output reg_sel, reg_write, reg_addr, reg_wdata,
    input  reg_rdata, reg_ready, general_pin_one, serial_data_out_pin
  );
endinterface : drc_link_if

// [compressor_device.sv]
// dynamic_compressor device end: level detector, gain state machine,
// event flags and the two host interrupt outputs, behind the register port.
// assumes samples, volume and detector levels are synchronous to pclk.
// Overview of operation
// - compare volume-stage output sample against threshold
// - threshold field selects -3 to -24 dBFS
// - host should program -24 dB threshold
// - exceeding threshold sets latched flags D3-D2
// - latched flags clear only on host read
// - live threshold flags follow current condition
// - hysteresis field selects 0 to 3 dB
// - activate above thr+hyst, release below thr-hyst
// - zero hysteresis switches at bare threshold
// - hold field delays decay start; recommend zero
// - attack lowers gain at programmed rate
// - attack steps span 4 dB to 1.2207e-5 dB
// - decay raises gain back at programmed rate
// - decay steps span 1.5625e-3 to 4.7683e-7 dB
// - 7f enables both channels, -24 dB, 3 dB
// - b6 gives recommended attack and decay pair
// - two interrupts, each with its event selection
// - each interrupt routes to either pin
// - config bit d0 picks single pulse or train
// - train runs until flag registers are read
// - control bits d6-d5 enable compression per channel
// - applied gain combines volume and compressor output
`include "drc_map.svh"
`timescale 1ns/100ps

module compressor_device import drc_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  drc_link_if.device_end    link,
  input  wire logic         sample_valid,
  input  wire logic [15:0]  sample_in,
  input  wire logic [7:0]   volume_gain,
  input  wire logic         button_pressed,
  input  wire logic         headset_inserted,
  output logic [32:0]       applied_gain,
  output logic              compress_active
);

  // threshold magnitudes in q15 of full scale, code 7 is the deepest
  function automatic logic [15:0] thr_lin(input logic [2:0] code);
    unique case (code)
      3'h0: thr_lin = 16'h5a9e;
      3'h1: thr_lin = 16'h4027;
      3'h2: thr_lin = 16'h2d6b;
      3'h3: thr_lin = 16'h2027;
      3'h4: thr_lin = 16'h16c3;
      3'h5: thr_lin = 16'h101d;
      3'h6: thr_lin = 16'h0b68;
      3'h7: thr_lin = 16'h0814;
    endcase
  endfunction : thr_lin

  // q12 factors for +/- hysteresis of 0..3 dB
  function automatic logic [12:0] hys_up(input logic [1:0] code);
    unique case (code)
      2'h0: hys_up = `Q12_ONE;
      2'h1: hys_up = 13'h11f4;
      2'h2: hys_up = 13'h1425;
      2'h3: hys_up = 13'h169a;
    endcase
  endfunction : hys_up

  function automatic logic [12:0] hys_dn(input logic [1:0] code);
    unique case (code)
      2'h0: hys_dn = `Q12_ONE;
      2'h1: hys_dn = 13'h0e41;
      2'h2: hys_dn = 13'h0cb3;
      2'h3: hys_dn = 13'h0b53;
    endcase
  endfunction : hys_dn

  // gain is tracked in 2^-24 dB units so the slowest decay still moves
  function automatic logic [31:0] atk_step(input logic [3:0] code);
    if (code == 4'h0) begin
      atk_step = `ATK_MAX_STEP;
    end else if (code <= `ATK_REF_CODE) begin
      atk_step = `ATK_REF_STEP << (`ATK_REF_CODE - code);
    end else begin
      atk_step = `ATK_REF_STEP >> (code - `ATK_REF_CODE);
    end
  endfunction : atk_step

  function automatic logic [31:0] dec_step(input logic [3:0] code);
    logic [31:0] s;
    s = `DEC_MAX_STEP >> code;
    dec_step = (s < `DEC_MIN_STEP) ? `DEC_MIN_STEP : s;
  endfunction : dec_step

  dev_state_type cur_ff;
  dev_state_type nxt_cur;

  logic [15:0] mag;
  logic [15:0] thr;
  logic [16:0] thr_hi;
  logic [16:0] thr_lo;
  logic [28:0] prod_hi;
  logic [28:0] prod_lo;
  logic [1:0]  en;
  logic        access;
  logic        rd;
  logic        stop_train;

  // full-scale negative saturates so magnitude never wraps
  assign mag = sample_in[15] ? ((sample_in == 16'h8000) ? 16'h7fff : 16'(-sample_in))
                             : sample_in;
  assign thr     = thr_lin(cur_ff.ctrl[`THR_LSB +: 3]);
  assign prod_hi = 29'(thr) * 29'(hys_up(cur_ff.ctrl[`HYS_LSB +: 2]));
  assign prod_lo = 29'(thr) * 29'(hys_dn(cur_ff.ctrl[`HYS_LSB +: 2]));
  assign thr_hi  = prod_hi[28:12];
  assign thr_lo  = prod_lo[28:12];
  assign en      = {cur_ff.ctrl[`CTRL_EN_L], cur_ff.ctrl[`CTRL_EN_R]};
  assign access  = link.reg_sel && !cur_ff.ready;
  assign rd      = access && !link.reg_write;
  assign stop_train = rd && (link.reg_addr == `ADDR_LATCHED ||
                             link.reg_addr == `ADDR_FLAGS_B ||
                             link.reg_addr == `ADDR_FLAGS_C);

  always_comb begin
    logic        ex;
    logic        ev_thr;
    logic        ev_btn;
    logic        ev_hset;
    logic        trig;
    logic [32:0] sum;
    logic [5:2]  set_bits;
    logic [7:0]  cfg;
    ex       = 1'b0;
    ev_thr   = 1'b0;
    ev_btn   = 1'b0;
    ev_hset  = 1'b0;
    trig     = 1'b0;
    sum      = 33'h0;
    set_bits = 4'h0;
    cfg      = 8'h00;
    nxt_cur  = cur_ff;
    nxt_cur.ready = access;

    if (access && link.reg_write) begin
      unique case (link.reg_addr)
        `ADDR_IRQ_A: nxt_cur.cfg[0] = link.reg_wdata;
        `ADDR_IRQ_B: nxt_cur.cfg[1] = link.reg_wdata;
        `ADDR_CTRL:  nxt_cur.ctrl   = link.reg_wdata;
        `ADDR_HOLD:  nxt_cur.hold   = link.reg_wdata;
        `ADDR_RATES: nxt_cur.rates  = link.reg_wdata;
        default: ;
      endcase
    end
    if (rd) begin
      unique case (link.reg_addr)
        `ADDR_LATCHED: nxt_cur.rdata = {2'h0, cur_ff.sticky, 2'h0};
        `ADDR_LIVE:    nxt_cur.rdata = {2'h0, cur_ff.btn_q, cur_ff.hset_q, cur_ff.live, 2'h0};
        `ADDR_IRQ_A:   nxt_cur.rdata = cur_ff.cfg[0];
        `ADDR_IRQ_B:   nxt_cur.rdata = cur_ff.cfg[1];
        `ADDR_CTRL:    nxt_cur.rdata = cur_ff.ctrl;
        `ADDR_HOLD:    nxt_cur.rdata = cur_ff.hold;
        `ADDR_RATES:   nxt_cur.rdata = cur_ff.rates;
        default:       nxt_cur.rdata = 8'h00;
      endcase
    end

    if (sample_valid) begin
      ex = {1'b0, mag} > {1'b0, thr};
      nxt_cur.live = {ex & en[1], ex & en[0]};
      ev_thr = |(nxt_cur.live & ~cur_ff.live);
      set_bits[`FLG_THR_L] = nxt_cur.live[1];
      set_bits[`FLG_THR_R] = nxt_cur.live[0];
      if (en == 2'h0) begin
        nxt_cur.st     = ST_IDLE;
        nxt_cur.active = 1'b0;
        nxt_cur.gr     = 32'h0;
      end else begin
        // thr_hi equals thr_lo equals thr when hysteresis code is zero
        if (!cur_ff.active && {1'b0, mag} > thr_hi) begin
          nxt_cur.active = 1'b1;
        end else if (cur_ff.active && {1'b0, mag} < thr_lo) begin
          nxt_cur.active = 1'b0;
        end
        if (nxt_cur.active) begin
          nxt_cur.st = ST_ATTACK;
          sum = {1'b0, cur_ff.gr} + {1'b0, atk_step(cur_ff.rates[`ATK_LSB +: 4])};
          nxt_cur.gr = (sum > {1'b0, `GR_MAX}) ? `GR_MAX : sum[31:0];
        end else begin
          unique case (cur_ff.st)
            ST_IDLE: ;
            ST_ATTACK: begin
              if (cur_ff.hold[`HOLD_LSB +: 4] == 4'h0) begin
                nxt_cur.st = ST_DECAY;
              end else begin
                nxt_cur.st       = ST_HOLD;
                nxt_cur.hold_cnt = 10'(cur_ff.hold[`HOLD_LSB +: 4] * `HOLD_UNIT);
              end
            end
            ST_HOLD: begin
              if (cur_ff.hold_cnt <= 10'h001) begin
                nxt_cur.st = ST_DECAY;
              end else begin
                nxt_cur.hold_cnt = cur_ff.hold_cnt - 10'h001;
              end
            end
            ST_DECAY: begin
              if (cur_ff.gr <= dec_step(cur_ff.rates[`DEC_LSB +: 4])) begin
                nxt_cur.gr = 32'h0;
                nxt_cur.st = ST_IDLE;
              end else begin
                nxt_cur.gr = cur_ff.gr - dec_step(cur_ff.rates[`DEC_LSB +: 4]);
              end
            end
          endcase
        end
      end
      // volume is 0.5 dB per code, one code is 2^23 gain units
      nxt_cur.gain = {{2{volume_gain[7]}}, volume_gain, 23'h0} - {1'b0, nxt_cur.gr};
    end

    nxt_cur.btn_q  = button_pressed;
    nxt_cur.hset_q = headset_inserted;
    ev_btn  = button_pressed & ~cur_ff.btn_q;
    ev_hset = headset_inserted ^ cur_ff.hset_q;
    set_bits[`FLG_BTN]  = ev_btn;
    set_bits[`FLG_HSET] = ev_hset;
    // an event landing on the clearing read survives it
    nxt_cur.sticky = (cur_ff.sticky & ~{4{rd && link.reg_addr == `ADDR_LATCHED}}) | set_bits;

    for (int i = 0; i < 2; i++) begin
      cfg  = cur_ff.cfg[i];
      trig = |({cfg[`CFG_HSET], cfg[`CFG_BTN], cfg[`CFG_THR]} & {ev_hset, ev_btn, ev_thr});
      if (stop_train) begin
        nxt_cur.train[i] = 1'b0;
      end
      if (trig) begin
        nxt_cur.pcnt[i]  = `IRQ_PULSE_CYC;
        nxt_cur.per[i]   = `IRQ_PERIOD_CYC;
        nxt_cur.train[i] = cfg[`CFG_TRAIN];
      end else begin
        if (cur_ff.pcnt[i] != 8'h00) begin
          nxt_cur.pcnt[i] = cur_ff.pcnt[i] - 8'h01;
        end
        if (cur_ff.train[i] && !stop_train) begin
          if (cur_ff.per[i] <= 8'h01) begin
            nxt_cur.pcnt[i] = `IRQ_PULSE_CYC;
            nxt_cur.per[i]  = `IRQ_PERIOD_CYC;
          end else begin
            nxt_cur.per[i] = cur_ff.per[i] - 8'h01;
          end
        end
      end
    end
    nxt_cur.gp_pin = ((nxt_cur.pcnt[0] != 8'h00) && !cur_ff.cfg[0][`CFG_ROUTE]) ||
                     ((nxt_cur.pcnt[1] != 8'h00) && !cur_ff.cfg[1][`CFG_ROUTE]);
    nxt_cur.do_pin = ((nxt_cur.pcnt[0] != 8'h00) && cur_ff.cfg[0][`CFG_ROUTE]) ||
                     ((nxt_cur.pcnt[1] != 8'h00) && cur_ff.cfg[1][`CFG_ROUTE]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff       <= '0;
      cur_ff.st    <= ST_IDLE;
      cur_ff.ctrl  <= `RST_CTRL;
      cur_ff.hold  <= `RST_HOLD;
      cur_ff.rates <= `RST_RATES;
      cur_ff.cfg   <= {`RST_IRQ_CFG, `RST_IRQ_CFG};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.reg_rdata           = cur_ff.rdata;
  assign link.reg_ready           = cur_ff.ready;
  assign link.general_pin_one     = cur_ff.gp_pin;
  assign link.serial_data_out_pin = cur_ff.do_pin;
  assign applied_gain             = cur_ff.gain;
  assign compress_active          = cur_ff.active;

endmodule : compressor_device

// [host_bridge.sv]
// host end: apb slave whose command register drives the compressor's
// register port and whose status register shows results and both pins.
// assumes an apb master on pclk; software does the programming sequence.
`include "drc_map.svh"
`timescale 1ns/100ps

module host_bridge import drc_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [31:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  drc_link_if.host_end      link
);

  host_state_type cur_ff;
  host_state_type nxt_cur;

  logic busy;
  logic is_cmd;
  logic is_stat;
  logic wait_busy;

  assign busy      = cur_ff.st != LK_IDLE;
  assign is_cmd    = paddr == `HOST_CMD;
  assign is_stat   = paddr == `HOST_STATUS;
  // a command write waits in the access phase until the link is free
  assign wait_busy = pwrite && is_cmd && busy;

  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.gp_q = link.general_pin_one;
    nxt_cur.do_q = link.serial_data_out_pin;

    unique case (cur_ff.st)
      LK_IDLE: ;
      LK_REQ: begin
        if (link.reg_ready) begin
          nxt_cur.st = LK_GAP;
          if (!cur_ff.wr) begin
            nxt_cur.rd_data = link.reg_rdata;
          end
        end
      end
      LK_GAP: nxt_cur.st = LK_IDLE;
    endcase

    if (psel && penable && cur_ff.pready) begin
      nxt_cur.pready  = 1'b0;
      nxt_cur.pslverr = 1'b0;
      if (pwrite && is_cmd) begin
        nxt_cur.st    = LK_REQ;
        nxt_cur.addr  = pwdata[14:8];
        nxt_cur.wdata = pwdata[7:0];
        nxt_cur.wr    = pwdata[`CMD_WRITE_BIT];
      end
    end else if (psel && !cur_ff.pready && !wait_busy) begin
      nxt_cur.pready  = 1'b1;
      nxt_cur.pslverr = !(is_cmd || is_stat);
      nxt_cur.prdata  = 32'h0;
      if (!pwrite && is_stat) begin
        nxt_cur.prdata = {14'h0, cur_ff.do_q, cur_ff.gp_q, cur_ff.rd_data, 7'h0, busy};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff    <= '0;
      cur_ff.st <= LK_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata         = cur_ff.prdata;
  assign pready         = cur_ff.pready;
  assign pslverr        = cur_ff.pslverr;
  assign link.reg_sel   = cur_ff.st == LK_REQ;
  assign link.reg_write = cur_ff.wr;
  assign link.reg_addr  = cur_ff.addr;
  assign link.reg_wdata = cur_ff.wdata;

endmodule : host_bridge

// [drc_link_props.sv]
// checker for the byte-wide register link and the two interrupt pins
// assumes one clock for both ends; tb_top instantiates it beside the link
`timescale 1ns/100ps

module drc_link_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       reg_sel,
  input wire logic       reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ready,
  input wire logic       general_pin_one,
  input wire logic       serial_data_out_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a : assert property (reg_ready |=> !reg_ready)
    else $error("ready held longer than one cycle");
  ready_answer_a : assert property (reg_sel && !reg_ready |=> reg_ready)
    else $error("no answer one cycle after request");
  ready_cause_a : assert property (reg_ready |-> $past(reg_sel) && !$past(reg_ready))
    else $error("answer without a request");
  sel_release_a : assert property (reg_ready |=> !reg_sel)
    else $error("select not dropped after answer");
  req_hold_a : assert property (reg_sel && !reg_ready |=>
    reg_sel && $stable(reg_addr) && $stable(reg_write) && $stable(reg_wdata))
    else $error("request changed before answer");
  sel_gap_a : assert property ($fell(reg_sel) |-> ##1 !reg_sel)
    else $error("no idle cycle between requests");
  rdata_hold_a : assert property ($changed(reg_rdata) |-> reg_ready)
    else $error("read data changed outside an answer");
  gp_width_a : assert property ($rose(general_pin_one) |-> general_pin_one[*8]
    ##1 general_pin_one ##1 general_pin_one ##1 !general_pin_one)
    else $error("general pin pulse not ten cycles");
  dout_width_a : assert property ($rose(serial_data_out_pin) |-> serial_data_out_pin[*8]
    ##1 serial_data_out_pin ##1 serial_data_out_pin ##1 !serial_data_out_pin)
    else $error("data out pin pulse not ten cycles");
  gp_gap_a : assert property ($fell(general_pin_one) |-> !general_pin_one[*8])
    else $error("general pin pulses too close");
endmodule : drc_link_props

// [tb_top.sv]
// self-checking bench: apb master on the host bridge, sample stream into the device
// assumes both ends share pclk; results of apb reads are checked from a queue
`include "drc_map.svh"
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sample_valid, button_pressed, headset_inserted, compress_active;
  logic [31:0] paddr, pwdata, prdata, lfsr_ff, r;
  logic [15:0] sample_in;
  logic [7:0]  volume_gain;
  logic [32:0] applied_gain, g;
  logic [65:0] expq[$];
  logic [65:0] en;
  int          error_cnt, checked, ng, nd, hy;
  real         thr;
  logic [6:0]  rw_addr[5] = '{`ADDR_CTRL, `ADDR_HOLD, `ADDR_RATES, `ADDR_IRQ_A, `ADDR_IRQ_B};
  logic [7:0]  rcode[3] = '{8'hb6, 8'hff, 8'h00};
  logic [32:0] astep[3] = '{`ATK_REF_STEP, `ATK_REF_STEP >> 4, `ATK_MAX_STEP};
  logic [32:0] dstep[3] = '{`DEC_MAX_STEP >> 6, `DEC_MIN_STEP, `DEC_MAX_STEP};

  drc_link_if link ();
  compressor_device compressor_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .sample_valid(sample_valid), .sample_in(sample_in), .volume_gain(volume_gain),
    .button_pressed(button_pressed), .headset_inserted(headset_inserted),
    .applied_gain(applied_gain), .compress_active(compress_active));
  host_bridge host_bridge_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  drc_link_props drc_link_props_inst (.pclk(pclk), .presetn(presetn),
    .reg_sel(link.reg_sel), .reg_write(link.reg_write), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ready(link.reg_ready),
    .general_pin_one(link.general_pin_one), .serial_data_out_pin(link.serial_data_out_pin));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  function automatic logic [15:0] lvl(input real db);
    return 16'($rtoi(32768.0 * (10.0 ** (db / 20.0))));
  endfunction : lvl

  task automatic summarize;
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // queue entry is {mask, expected} over {pslverr, prdata}
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [32:0] m, input logic [32:0] e, output logic [31:0] rd);
    expq.push_back({m, e});
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic dev(input logic wr, input logic [6:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    logic [31:0] s;
    apb(1'b1, `HOST_CMD, {15'h0, wr, 1'b0, a, d}, 33'h1_0000_0000, 33'h0, s);
    s = 32'h1;
    while (s[0] === 1'b1) apb(1'b0, `HOST_STATUS, 32'h0, 33'h0, 33'h0, s);
    if (!wr) apb(1'b0, `HOST_STATUS, 32'h0, 33'h1_0000_ff01, {17'h0, e, 8'h00}, s);
  endtask : dev

  task automatic send(input logic [15:0] s);
    @(posedge pclk);
    sample_valid <= 1'b1; sample_in <= s;
    @(posedge pclk);
    sample_valid <= 1'b0; sample_in <= ~s;
    #1;
  endtask : send

  // counts rising edges of both pins over one window of 450 cycles
  task automatic count(output int cg, output int cd);
    logic pg, pd;
    cg = 0; cd = 0; pg = 1'b0; pd = 1'b0;
    repeat (450) begin
      @(posedge pclk);
      #1;
      if (link.general_pin_one === 1'b1 && !pg) cg++;
      if (link.serial_data_out_pin === 1'b1 && !pd) cd++;
      pg = (link.general_pin_one === 1'b1); pd = (link.serial_data_out_pin === 1'b1);
    end
  endtask : count

  always @(posedge pclk) if (psel && penable && pready) begin
    en = expq.pop_front();
    `CHK({pslverr, prdata} & en[65:33], en[32:0] & en[65:33])
  end

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    summarize();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    sample_valid = 1'b0; sample_in = 16'h0; button_pressed = 1'b0; headset_inserted = 1'b0;
    lfsr_ff = 32'd32900; volume_gain = lfsr_ff[7:0];
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    lfsr_ff = lfsr_next(lfsr_ff);
    volume_gain <= lfsr_ff[7:0];
    send(16'h0020);
    `CHK(applied_gain, {{2{volume_gain[7]}}, volume_gain, 23'h0})
    for (int i = 0; i < 5; i++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      dev(1'b0, rw_addr[i], 8'h00, `RST_CTRL);
      dev(1'b1, rw_addr[i], lfsr_ff[7:0], 8'h00);
      dev(1'b0, rw_addr[i], 8'h00, lfsr_ff[7:0]);
      dev(1'b1, rw_addr[i], 8'h00, 8'h00);
    end
    apb(1'b0, 32'h8, 32'h0, 33'h1_ffff_ffff, 33'h1_0000_0000, r);
    dev(1'b0, 7'h10, 8'h00, 8'h00);
    dev(1'b0, `ADDR_FLAGS_B, 8'h00, 8'h00);
    dev(1'b1, `ADDR_CTRL, 8'h1f, 8'h00);
    send(16'h7000);
    `CHK(compress_active, 1'b0)
    // slow attack here so the reduction stays far from its cap
    dev(1'b1, `ADDR_RATES, 8'hff, 8'h00);
    for (int k = 0; k < 8; k++) begin
      thr = -3.0 * (k + 1);
      hy = k % 4;
      dev(1'b1, `ADDR_CTRL, 8'(32'h60 | (k << 2) | hy), 8'h00);
      send(16'h0020);
      send(lvl(thr + hy - 0.5));
      `CHK(compress_active, 1'b0)
      send(lvl(thr + hy + 0.5));
      `CHK(compress_active, 1'b1)
      send(lvl(thr - hy + 0.5));
      `CHK(compress_active, 1'b1)
      send(lvl(thr - hy - 0.5));
      `CHK(compress_active, 1'b0)
    end
    dev(1'b0, `ADDR_CTRL, 8'h00, 8'h7f);
    dev(1'b0, `ADDR_LATCHED, 8'h00, 8'h0c);
    dev(1'b0, `ADDR_LATCHED, 8'h00, 8'h00);
    send(16'h7000);
    dev(1'b0, `ADDR_LIVE, 8'h00, 8'h0c);
    send(16'h0020);
    dev(1'b0, `ADDR_LIVE, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++) begin
      dev(1'b1, `ADDR_RATES, rcode[i], 8'h00);
      dev(1'b0, `ADDR_RATES, 8'h00, rcode[i]);
      send(16'h7000);
      send(16'h7000);
      g = applied_gain;
      send(16'h7000);
      `CHK(g - applied_gain, astep[i])
      send(16'h0020);
      send(16'h0020);
      g = applied_gain;
      send(16'h0020);
      `CHK(applied_gain - g, dstep[i])
    end
    dev(1'b1, `ADDR_HOLD, 8'h08, 8'h00);
    send(16'h7000);
    send(16'h0020);
    g = applied_gain;
    repeat (10) send(16'h0020);
    `CHK(applied_gain, g)
    repeat (70) send(16'h0020);
    `CHK(applied_gain > g, 1'b1)
    dev(1'b1, `ADDR_IRQ_A, 8'h20, 8'h00);
    send(16'h7000);
    count(ng, nd);
    `CHK({ng, nd}, {32'd1, 32'd0})
    dev(1'b1, `ADDR_IRQ_A, 8'h22, 8'h00);
    send(16'h0020);
    send(16'h7000);
    count(ng, nd);
    `CHK({ng, nd}, {32'd0, 32'd1})
    dev(1'b1, `ADDR_IRQ_A, 8'h00, 8'h00);
    dev(1'b1, `ADDR_IRQ_B, 8'h43, 8'h00);
    send(16'h0020);
    send(16'h7000);
    count(ng, nd);
    `CHK({ng, nd}, {32'd0, 32'd0})
    @(posedge pclk);
    button_pressed <= 1'b1;
    count(ng, nd);
    `CHK(nd, 3)
    dev(1'b0, `ADDR_LATCHED, 8'h00, 8'h2c);
    count(ng, nd);
    `CHK({ng, nd}, {32'd0, 32'd0})
    dev(1'b1, `ADDR_IRQ_A, 8'h80, 8'h00);
    @(posedge pclk);
    headset_inserted <= 1'b1;
    count(ng, nd);
    `CHK(ng, 1)
    dev(1'b0, `ADDR_LATCHED, 8'h00, 8'h10);
    summarize();
  end
endmodule : tb_top
